// >>> inc/psm_pkg.sv
// Constants, command codes and number-format helpers for the manager command block.
// Assumes one 40 MHz core clock and a 200 us step tick from outside.
package psm_pkg;

  localparam int          NCH            = 8;
  localparam int          CLK_MHZ        = 40;

  // Command codes
  localparam logic [7:0]  CMD_CLEAR_FLT  = 8'h03;
  localparam logic [7:0]  CMD_VOUT_MAX   = 8'hDD;
  localparam logic [7:0]  CMD_VIN_MAX    = 8'hDE;
  localparam logic [7:0]  CMD_TEMP_MAX   = 8'hDF;
  localparam logic [7:0]  CMD_DAC_CODE   = 8'hE0;
  localparam logic [7:0]  CMD_PG_DELAY   = 8'hE1;
  localparam logic [7:0]  CMD_PAD_STATE  = 8'hE5;

  // Reset values
  localparam logic [15:0] VOUT_MAX_RST   = 16'hF800;
  localparam logic [15:0] L11_MAX_RST    = 16'h7C00;
  localparam logic [15:0] PG_DELAY_RST   = 16'h0000;
  localparam logic [9:0]  DAC_CODE_RST   = 10'h000;

  // Field layout
  localparam int          DAC_W          = 10;
  localparam int          L11_EXP_LSB    = 11;
  localparam int          L11_SHIFT_BIAS = 16;
  localparam logic [1:0]  DAC_MODE_HARD  = 2'b10;
  localparam logic [1:0]  DAC_MODE_SOFT  = 2'b11;
  localparam logic [1:0]  ASEL_RESERVED  = 2'b01;

  // Delay stepping
  localparam int          STEP_US        = 200;
  localparam int          DELAY_CAP_MS   = 13100;
  localparam logic [15:0] CAP_STEPS      = 16'(DELAY_CAP_MS * 1000 / STEP_US);
  localparam logic [2:0]  MS_TO_STEPS    = 3'(1000 / STEP_US);

  // Linear 11-bit value scaled by 2^16, two's complement
  function automatic logic signed [47:0] l11Value(input logic [15:0] w);
    logic signed [4:0]  e;
    logic signed [47:0] m;
    e = w[15:L11_EXP_LSB];
    m = 48'(signed'(w[L11_EXP_LSB-1:0]));
    l11Value = m <<< (6'(e) + 6'(L11_SHIFT_BIAS));
  endfunction : l11Value

  // Milliseconds in linear 11-bit form to rounded, capped step count
  function automatic logic [15:0] l11ToSteps(input logic [15:0] w);
    logic signed [4:0] e;
    logic [47:0]       v;
    logic [4:0]        sh;
    e  = w[15:L11_EXP_LSB];
    v  = 48'(w[L11_EXP_LSB-1:0]) * 48'(MS_TO_STEPS);
    sh = 5'(-e);
    if (w[L11_EXP_LSB-1]) begin
      v = '0;
    end else if (e >= 0) begin
      v = v << 5'(e);
    end else begin
      v = (v + (48'h1 << (sh - 5'h1))) >> sh;
    end
    l11ToSteps = (v > 48'(CAP_STEPS)) ? CAP_STEPS : v[15:0];
  endfunction : l11ToSteps

endpackage : psm_pkg

// >>> inc/pgood_tmr_if.sv
// Link between the command block and one power-good delay timer.
// Assumes both ends share core_clk.
`timescale 1ns/10ps
interface pgood_tmr_if;
  logic        stepTick;
  logic [15:0] limitSteps;
  logic        condGood;
  logic        outGood;

  modport ctrl (output stepTick, output limitSteps, output condGood, input outGood);
  modport tmr  (input stepTick, input limitSteps, input condGood, output outGood);
endinterface : pgood_tmr_if

// >>> rtl/pgood_delay_timer.sv
// Delays one channel's power-good by a number of step ticks.
// Assumes stepTick is a one-cycle pulse per 200 us step.
`timescale 1ns/10ps
module pgood_delay_timer (
  input  wire logic core_clk,
  input  wire logic rst,
  pgood_tmr_if.tmr  tmr
);

  typedef enum logic [1:0] {WAIT_COND, COUNTING, ASSERTED} tmr_state_e;

  tmr_state_e  state_r;
  logic [15:0] steps_r;
  logic        good_r;

  assign tmr.outGood = good_r;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= WAIT_COND;
      steps_r <= '0;
      good_r  <= 1'b0;
    end else if (!tmr.condGood) begin
      state_r <= WAIT_COND;
      steps_r <= '0;
      good_r  <= 1'b0;
    end else begin
      unique case (state_r)
        WAIT_COND: begin
          state_r <= COUNTING;
          steps_r <= '0;
        end
        COUNTING: begin
          if (steps_r >= tmr.limitSteps) begin
            state_r <= ASSERTED;
            good_r  <= 1'b1;
          end else if (tmr.stepTick) begin
            steps_r <= steps_r + 16'h0001;
          end
        end
        ASSERTED: good_r <= 1'b1;
      endcase
    end
  end

endmodule : pgood_delay_timer

// >>> rtl/psm_cmd_regs.sv
// Command registers: peak records, manual DAC code, power-good delay, pad readback.
// Assumes a command decoder hands over one command per cycle with page already resolved,
// and that ADC, comparator and sequencer results arrive synchronous to core_clk.
`timescale 1ns/10ps

// Operation
// - Each channel keeps its highest measured output voltage, 16-bit linear form.
// - Output peak resets to F800 on reset, page clear, channel turning on.
// - Keep highest measured input voltage as linear 11-bit word.
// - Input peak resets to 7C00 on reset, any clear, any channel turning on.
// - Keep highest measured die temperature as linear 11-bit word.
// - Temperature peak resets to 7C00 on reset, any clear, any turn-on.
// - DAC register: 10-bit code low, upper six bits read zero.
// - DAC code write taken only when on, rise done, mode 10b/11b.
// - Mode becoming 10b hard-connects DAC using held code.
// - Mode becoming 11b starts a soft connect instead.
// - After soft connect, code reads the value that connected cleanly.
// - DAC code writes ignored while mode is 00b or 01b.
// - Power-good output asserts a programmed delay after internal condition valid.
// - Delay given in ms, rounded to 200 us steps, capped 13.1 s.
// - Delay reads back exactly as last written.
// - Off-source bit 1: drop power-good from fast undervoltage comparator.
// - Off-source bit 0: drop power-good from slow polled threshold.
// - Pad readback is read-only; low ten bits are raw pins.
// - Bit 15 zero while pulling power-good low; bit 14 same for alert.
// - Bits 13..10 zero while driving fault-share pins 3..0 low.
// - Address pins as 2-bit codes in 9:8 and 7:6.
// - Bits 5,4 give raw levels of channel-control pins.
// - Bits 3..0 give raw levels of fault-share pins.
module psm_cmd_regs (
  input  wire logic                                      core_clk,
  input  wire logic                                      rst,
  // Command port
  input  wire logic                                      cmdValid,
  input  wire logic                                      cmdWrite,
  input  wire logic [7:0]                                cmdCode,
  input  wire logic [2:0]                                cmdPage,
  input  wire logic [15:0]                               cmdWdata,
  output logic      [15:0]                               rdData_r,
  output logic                                           rdValid_r,
  output logic                                           cmdUnknown_r,
  // Telemetry
  input  wire logic                                      voutValid,
  input  wire logic [2:0]                                voutChan,
  input  wire logic [15:0]                               voutData,
  input  wire logic                                      vinValid,
  input  wire logic [15:0]                               vinData,
  input  wire logic                                      tempValid,
  input  wire logic [15:0]                               tempData,
  input  wire logic [3:0]                                oddMeasCurrent,
  // Channel state and configuration
  input  wire logic [psm_pkg::NCH-1:0]                   chanOn,
  input  wire logic [psm_pkg::NCH-1:0]                   riseDone,
  input  wire logic [psm_pkg::NCH-1:0][1:0]              dacMode,
  input  wire logic [psm_pkg::NCH-1:0]                   softDone,
  input  wire logic [psm_pkg::NCH-1:0][psm_pkg::DAC_W-1:0] softCode,
  output logic      [psm_pkg::NCH-1:0][psm_pkg::DAC_W-1:0] dacCode_r,
  output logic      [psm_pkg::NCH-1:0]                   dacHardConnect_r,
  output logic      [psm_pkg::NCH-1:0]                   dacSoftConnect_r,
  // Power good
  input  wire logic                                      shareClkPresent,
  input  wire logic                                      shareStepTick,
  input  wire logic                                      oscStepTick,
  input  wire logic [psm_pkg::NCH-1:0]                   pgoodOnCond,
  input  wire logic [psm_pkg::NCH-1:0]                   pgoodOffSourceSel,
  input  wire logic [psm_pkg::NCH-1:0]                   uvFastComp,
  input  wire logic [psm_pkg::NCH-1:0]                   pgoodOffPolled,
  output logic      [psm_pkg::NCH-1:0]                   pgoodChan_r,
  output logic                                           pgoodPinOut_r,
  output logic                                           pgoodPinOe_r,
  // Pads
  input  wire logic                                      alertDriveLow,
  input  wire logic [3:0]                                faultShareDriveLow,
  input  wire logic [1:0]                                addrSelectPinA,
  input  wire logic [1:0]                                addrSelectPinB,
  input  wire logic                                      chanCtrlPinA,
  input  wire logic                                      chanCtrlPinB,
  input  wire logic [3:0]                                faultSharePinN
);

  localparam int NCH = psm_pkg::NCH;

  logic [NCH-1:0][15:0] voutMax_r;
  logic [15:0]          vinMax_r;
  logic [15:0]          tempMax_r;
  logic [NCH-1:0][15:0] pgDelay_r;
  logic [NCH-1:0][15:0] pgSteps_r;
  logic [NCH-1:0][1:0]  dacModePrev_r;
  logic [NCH-1:0]       chanOnPrev_r;
  logic [NCH-1:0]       pgoodInt_r;
  logic [NCH-1:0]       tmrGood;
  logic [NCH-1:0]       turnOn;
  logic [NCH-1:0]       voutRearm;
  logic                 anyTurnOn;
  logic                 clearAny;
  logic                 isWrite;
  logic                 isRead;
  logic                 stepTick;
  logic [15:0]          padWord;
  logic [15:0]          rdData_nxt;
  logic                 known_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and events
  assign isWrite   = cmdValid && cmdWrite;
  assign isRead    = cmdValid && !cmdWrite;
  assign clearAny  = isWrite && (cmdCode == psm_pkg::CMD_CLEAR_FLT);
  assign turnOn    = chanOn & ~chanOnPrev_r;
  assign anyTurnOn = |turnOn;
  assign stepTick  = shareClkPresent ? shareStepTick : oscStepTick;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      chanOnPrev_r  <= '0;
      dacModePrev_r <= '0;
    end else begin
      chanOnPrev_r  <= chanOn;
      dacModePrev_r <= dacMode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output voltage peaks, one per channel
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_chan
      logic measCurrent;
      logic voutHit;
      logic pageClear;
      logic dacWrOk;
      pgood_tmr_if tmrLink ();

      assign measCurrent = (ch % 2 == 1) && oddMeasCurrent[ch / 2];
      assign voutHit     = voutValid && (voutChan == 3'(ch)) && !measCurrent;
      assign pageClear   = clearAny && (cmdPage == 3'(ch));
      assign voutRearm[ch] = voutMax_r[ch] == psm_pkg::VOUT_MAX_RST;

      always_ff @(posedge core_clk) begin
        if (rst) begin
          voutMax_r[ch] <= psm_pkg::VOUT_MAX_RST;
        end else if (pageClear || turnOn[ch]) begin
          voutMax_r[ch] <= psm_pkg::VOUT_MAX_RST;
        end else if (voutHit && (voutRearm[ch] || voutData > voutMax_r[ch])) begin
          voutMax_r[ch] <= voutData;
        end
      end

      //////////////////////////////////////////////////////////////////////
      // Manual DAC code and connect requests
      assign dacWrOk = isWrite && (cmdCode == psm_pkg::CMD_DAC_CODE) && (cmdPage == 3'(ch))
                       && chanOn[ch] && riseDone[ch] && dacMode[ch][1];

      always_ff @(posedge core_clk) begin
        if (rst) begin
          dacCode_r[ch] <= psm_pkg::DAC_CODE_RST;
        end else if (softDone[ch] && dacMode[ch] == psm_pkg::DAC_MODE_SOFT) begin
          dacCode_r[ch] <= softCode[ch];
        end else if (dacWrOk) begin
          dacCode_r[ch] <= cmdWdata[psm_pkg::DAC_W-1:0];
        end
      end

      always_ff @(posedge core_clk) begin
        if (rst) begin
          dacHardConnect_r[ch] <= 1'b0;
          dacSoftConnect_r[ch] <= 1'b0;
        end else begin
          dacHardConnect_r[ch] <= (dacMode[ch] == psm_pkg::DAC_MODE_HARD)
                                  && (dacModePrev_r[ch] != psm_pkg::DAC_MODE_HARD);
          dacSoftConnect_r[ch] <= (dacMode[ch] == psm_pkg::DAC_MODE_SOFT)
                                  && (dacModePrev_r[ch] != psm_pkg::DAC_MODE_SOFT);
        end
      end

      //////////////////////////////////////////////////////////////////////
      // Power-good delay setting
      always_ff @(posedge core_clk) begin
        if (rst) begin
          pgDelay_r[ch] <= psm_pkg::PG_DELAY_RST;
          pgSteps_r[ch] <= psm_pkg::l11ToSteps(psm_pkg::PG_DELAY_RST);
        end else if (isWrite && cmdCode == psm_pkg::CMD_PG_DELAY && cmdPage == 3'(ch)) begin
          pgDelay_r[ch] <= cmdWdata;
          pgSteps_r[ch] <= psm_pkg::l11ToSteps(cmdWdata);
        end
      end

      // Internal condition: set by on-condition, dropped by the selected source
      always_ff @(posedge core_clk) begin
        if (rst) begin
          pgoodInt_r[ch] <= 1'b0;
        end else if (!chanOn[ch]) begin
          pgoodInt_r[ch] <= 1'b0;
        end else if (pgoodOffSourceSel[ch] ? uvFastComp[ch] : pgoodOffPolled[ch]) begin
          pgoodInt_r[ch] <= 1'b0;
        end else if (pgoodOnCond[ch]) begin
          pgoodInt_r[ch] <= 1'b1;
        end
      end

      assign tmrLink.stepTick   = stepTick;
      assign tmrLink.limitSteps = pgSteps_r[ch];
      assign tmrLink.condGood   = pgoodInt_r[ch];
      assign tmrGood[ch]        = tmrLink.outGood;

      pgood_delay_timer u_tmr (
        .core_clk (core_clk),
        .rst      (rst),
        .tmr      (tmrLink.tmr)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Input voltage and die temperature peaks
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vinMax_r <= psm_pkg::L11_MAX_RST;
    end else if (clearAny || anyTurnOn) begin
      vinMax_r <= psm_pkg::L11_MAX_RST;
    end else if (vinValid && psm_pkg::l11Value(vinData) > psm_pkg::l11Value(vinMax_r)) begin
      vinMax_r <= vinData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tempMax_r <= psm_pkg::L11_MAX_RST;
    end else if (clearAny || anyTurnOn) begin
      tempMax_r <= psm_pkg::L11_MAX_RST;
    end else if (tempValid && psm_pkg::l11Value(tempData) > psm_pkg::l11Value(tempMax_r)) begin
      tempMax_r <= tempData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-good outputs and open-drain pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pgoodChan_r   <= '0;
      pgoodPinOut_r <= 1'b0;
      pgoodPinOe_r  <= 1'b1;
    end else begin
      pgoodChan_r   <= tmrGood;
      pgoodPinOut_r <= 1'b0;
      pgoodPinOe_r  <= !(&tmrGood);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad readback, raw pins ahead of any filtering
  assign padWord = {!pgoodPinOe_r,
                    !alertDriveLow,
                    ~faultShareDriveLow,
                    addrSelectPinB,
                    addrSelectPinA,
                    chanCtrlPinB,
                    chanCtrlPinA,
                    faultSharePinN};

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer
  always_comb begin
    rdData_nxt = 16'h0000;
    known_nxt  = 1'b1;
    unique case (cmdCode)
      psm_pkg::CMD_VOUT_MAX:  rdData_nxt = voutMax_r[cmdPage];
      psm_pkg::CMD_VIN_MAX:   rdData_nxt = vinMax_r;
      psm_pkg::CMD_TEMP_MAX:  rdData_nxt = tempMax_r;
      psm_pkg::CMD_DAC_CODE:  rdData_nxt = 16'(dacCode_r[cmdPage]);
      psm_pkg::CMD_PG_DELAY:  rdData_nxt = pgDelay_r[cmdPage];
      psm_pkg::CMD_PAD_STATE: rdData_nxt = padWord;
      psm_pkg::CMD_CLEAR_FLT: known_nxt  = cmdWrite;
      default:                known_nxt  = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdData_r     <= 16'h0000;
      rdValid_r    <= 1'b0;
      cmdUnknown_r <= 1'b0;
    end else begin
      rdValid_r    <= isRead && known_nxt;
      cmdUnknown_r <= cmdValid && (!known_nxt || (cmdWrite && cmdCode != psm_pkg::CMD_CLEAR_FLT
                      && cmdCode != psm_pkg::CMD_DAC_CODE && cmdCode != psm_pkg::CMD_PG_DELAY));
      if (isRead) begin
        rdData_r <= known_nxt ? rdData_nxt : 16'h0000;
      end
    end
  end

endmodule : psm_cmd_regs

// >>> verif/psm_cmd_regs_sva.sv
// Port-level checker for the command register block.
// Assumes it is bound onto psm_cmd_regs; one clock domain.
`timescale 1ns/10ps
module psm_cmd_regs_sva (
  input wire logic            core_clk,
  input wire logic            rst,
  input wire logic            cmdValid,
  input wire logic            cmdWrite,
  input wire logic [7:0]      cmdCode,
  input wire logic [2:0]      cmdPage,
  input wire logic [15:0]     cmdWdata,
  input wire logic [15:0]     rdData_r,
  input wire logic            rdValid_r,
  input wire logic [7:0]      chanOn,
  input wire logic [7:0]      riseDone,
  input wire logic [7:0][1:0] dacMode,
  input wire logic [7:0]      softDone,
  input wire logic [7:0][9:0] dacCode_r,
  input wire logic [7:0]      dacHardConnect_r,
  input wire logic [7:0]      dacSoftConnect_r,
  input wire logic [7:0]      pgoodOnCond,
  input wire logic [7:0]      pgoodOffSourceSel,
  input wire logic [7:0]      uvFastComp,
  input wire logic [7:0]      pgoodOffPolled,
  input wire logic [7:0]      pgoodChan_r,
  input wire logic            pgoodPinOut_r,
  input wire logic            alertDriveLow,
  input wire logic [3:0]      faultShareDriveLow,
  input wire logic [1:0]      addrSelectPinA,
  input wire logic [1:0]      addrSelectPinB,
  input wire logic            chanCtrlPinA,
  input wire logic            chanCtrlPinB,
  input wire logic [3:0]      faultSharePinN
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  sequence sRead(logic [7:0] c);
    cmdValid && !cmdWrite && cmdCode == c;
  endsequence
  sequence sDacWr;
    cmdValid && cmdWrite && cmdCode == psm_pkg::CMD_DAC_CODE;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  AST_PAD_LOW: assert property (
    sRead(psm_pkg::CMD_PAD_STATE) |=> rdValid_r && rdData_r[9:0] == $past({addrSelectPinB,
      addrSelectPinA, chanCtrlPinB, chanCtrlPinA, faultSharePinN}))
    else $error("pad readback low bits wrong");
  AST_PAD_DRIVE: assert property (
    sRead(psm_pkg::CMD_PAD_STATE) |=> rdData_r[14:10] == ~$past({alertDriveLow,
      faultShareDriveLow}))
    else $error("pad readback drive bits wrong");
  AST_DAC_UPPER: assert property (
    sRead(psm_pkg::CMD_DAC_CODE) |=> rdValid_r && rdData_r[15:10] == 6'h00)
    else $error("dac readback upper bits not zero");
  AST_DAC_IGNORE: assert property (
    sDacWr and !dacMode[cmdPage][1] |=> dacCode_r[$past(cmdPage)] == $past(dacCode_r[cmdPage]))
    else $error("dac write taken in wrong mode");
  AST_DAC_TAKE: assert property (
    sDacWr and chanOn[cmdPage] && riseDone[cmdPage] && dacMode[cmdPage][1] && !softDone[cmdPage]
      |=> dacCode_r[$past(cmdPage)] == $past(cmdWdata[9:0]))
    else $error("dac write not taken");
  AST_HARD: assert property (
    dacMode[0] == psm_pkg::DAC_MODE_HARD && $past(dacMode[0]) != psm_pkg::DAC_MODE_HARD
      |=> dacHardConnect_r[0])
    else $error("hard connect missing");
  AST_SOFT: assert property (
    dacMode[0] == psm_pkg::DAC_MODE_SOFT && $past(dacMode[0]) != psm_pkg::DAC_MODE_SOFT
      |=> dacSoftConnect_r[0] && !dacHardConnect_r[0])
    else $error("soft connect missing");
  AST_PG_UV: assert property (
    chanOn[0] && pgoodOffSourceSel[0] && uvFastComp[0] && !pgoodOnCond[0] |-> ##3 !pgoodChan_r[0])
    else $error("power good not dropped by fast source");
  AST_PG_POLL: assert property (
    chanOn[0] && !pgoodOffSourceSel[0] && pgoodOffPolled[0] && !pgoodOnCond[0]
      |-> ##3 !pgoodChan_r[0])
    else $error("power good not dropped by polled source");
  AST_PIN_OUT: assert property (!pgoodPinOut_r)
    else $error("open drain pin driven high");
endmodule : psm_cmd_regs_sva

bind psm_cmd_regs psm_cmd_regs_sva i_psm_cmd_regs_sva (.*);

// >>> verif/pmbus_host_model.sv
// Host side of the command port: one read or write at a time.
// Assumes a read answer stands one cycle after the command is taken.
`timescale 1ns/10ps
module pmbus_host_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] rdData_r,
  input  wire logic        rdValid_r,
  input  wire logic        cmdUnknown_r,
  output logic             cmdValid,
  output logic             cmdWrite,
  output logic [7:0]       cmdCode,
  output logic [2:0]       cmdPage,
  output logic [15:0]      cmdWdata
);
  initial begin
    {cmdValid, cmdWrite, cmdCode, cmdPage, cmdWdata} = '0;
  end

  task automatic xfer(input logic w, input logic [7:0] c, input logic [2:0] p,
                      input logic [15:0] d, output logic [15:0] q, output logic v,
                      output logic u);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdWrite <= w;
    cmdCode  <= c;
    cmdPage  <= p;
    cmdWdata <= d;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    // Released code and data carry junk, never the last value; page and write keep theirs
    cmdCode  <= ~c;
    cmdWdata <= ~d;
    #1;
    q = rdData_r;
    v = rdValid_r;
    u = cmdUnknown_r;
  endtask : xfer
endmodule : pmbus_host_model

// >>> verif/test_psm_cmd_regs.sv
// Self-checking bench for the command register block.
// Assumes the host model drives the command port; pins and telemetry driven here.
`timescale 1ns/10ps
module test_psm_cmd_regs;
  logic        core_clk, rst, cmdValid, cmdWrite, rdValid_r, cmdUnknown_r;
  logic [7:0]  cmdCode;
  logic [2:0]  cmdPage, voutChan;
  logic [15:0] cmdWdata, rdData_r, voutData, vinData, tempData;
  logic        voutValid, vinValid, tempValid, shareClkPresent, shareStepTick, oscStepTick;
  logic        pgoodPinOut_r, pgoodPinOe_r, alertDriveLow, chanCtrlPinA, chanCtrlPinB;
  logic [3:0]  oddMeasCurrent, faultShareDriveLow, faultSharePinN;
  logic [1:0]  addrSelectPinA, addrSelectPinB;
  logic [7:0]  chanOn, riseDone, softDone, dacHardConnect_r, dacSoftConnect_r, pgoodOnCond;
  logic [7:0]  pgoodOffSourceSel, uvFastComp, pgoodOffPolled, pgoodChan_r;
  logic [7:0][1:0] dacMode;
  logic [7:0][9:0] softCode, dacCode_r;
  logic [14:0] pat;
  int          n_fail, n_checks;

  psm_cmd_regs     i_psm_cmd_regs (.*);
  pmbus_host_model i_pmbus_host_model (.*);

  always #12.5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic rd(input logic [7:0] c, input logic [2:0] p, input logic [15:0] exp);
    logic [15:0] q;
    logic        v;
    logic        u;
    i_pmbus_host_model.xfer(1'b0, c, p, 16'h0000, q, v, u);
    check({u, v}, 16'h0001);
    check(q, exp);
  endtask : rd

  task automatic wr(input logic [7:0] c, input logic [2:0] p, input logic [15:0] d,
                    input logic eu);
    logic [15:0] q;
    logic        v;
    logic        u;
    i_pmbus_host_model.xfer(1'b1, c, p, d, q, v, u);
    check({15'h0000, u}, {15'h0000, eu});
  endtask : wr

  // One sample pulse; k picks output, input or temperature
  task automatic samp(input int k, input logic [15:0] v);
    @(posedge core_clk);
    {voutValid, vinValid, tempValid} <= {k == 0, k == 1, k == 2};
    {voutData, vinData, tempData} <= {v, v, v};
    @(posedge core_clk);
    {voutValid, vinValid, tempValid} <= 3'h0;
    {voutData, vinData, tempData} <= ~{v, v, v};
  endtask : samp

  // Selected source ticks once, the other one twice, per step
  task automatic ticks(input int n, input logic sh);
    repeat (n) begin
      @(posedge core_clk);
      {shareStepTick, oscStepTick} <= {sh, !sh};
      @(posedge core_clk);
      {shareStepTick, oscStepTick} <= {!sh, sh};
      @(posedge core_clk);
    end
    @(posedge core_clk);
    {shareStepTick, oscStepTick} <= 2'h0;
  endtask : ticks

  task automatic waitPg(input logic e);
    for (int i = 0; i < 8 && pgoodChan_r[0] !== e; i++) begin
      @(posedge core_clk);
    end
    #1;
    check({15'h0000, pgoodChan_r[0]}, {15'h0000, e});
  endtask : waitPg

  task automatic holdPg(input logic e);
    repeat (6) @(posedge core_clk);
    check({15'h0000, pgoodChan_r[0]}, {15'h0000, e});
  endtask : holdPg

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    n_fail++;
    complete_run();
  end

  initial begin
    {core_clk, n_fail, n_checks, pat} = '0;
    rst = 1'b1;
    {voutValid, vinValid, tempValid, voutChan, voutData, vinData, tempData} = '0;
    {oddMeasCurrent, chanOn, riseDone, dacMode, softDone, softCode, shareClkPresent} = '0;
    {shareStepTick, oscStepTick, pgoodOnCond, pgoodOffSourceSel, uvFastComp} = '0;
    {pgoodOffPolled, alertDriveLow, faultShareDriveLow, addrSelectPinA} = '0;
    {addrSelectPinB, chanCtrlPinA, chanCtrlPinB, faultSharePinN} = '0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rd(psm_pkg::CMD_VOUT_MAX, 3'h0, 16'hF800);
    rd(psm_pkg::CMD_VIN_MAX, 3'h0, 16'h7C00);
    rd(psm_pkg::CMD_TEMP_MAX, 3'h0, 16'h7C00);
    samp(0, 16'h1234);
    samp(0, 16'h1000);
    samp(1, 16'hD200);
    samp(1, 16'hD100);
    samp(2, 16'h0019);
    samp(2, 16'h07FF);
    rd(psm_pkg::CMD_VOUT_MAX, 3'h0, 16'h1234);
    rd(psm_pkg::CMD_VIN_MAX, 3'h0, 16'hD200);
    rd(psm_pkg::CMD_TEMP_MAX, 3'h0, 16'h0019);
    wr(psm_pkg::CMD_CLEAR_FLT, 3'h1, 16'h0000, 1'b0);
    rd(psm_pkg::CMD_VOUT_MAX, 3'h0, 16'h1234);
    rd(psm_pkg::CMD_VIN_MAX, 3'h0, 16'h7C00);
    rd(psm_pkg::CMD_TEMP_MAX, 3'h0, 16'h7C00);
    wr(psm_pkg::CMD_CLEAR_FLT, 3'h0, 16'h0000, 1'b0);
    rd(psm_pkg::CMD_VOUT_MAX, 3'h0, 16'hF800);
    samp(0, 16'h0800);
    samp(2, 16'h0033);
    chanOn <= 8'h01;
    rd(psm_pkg::CMD_VOUT_MAX, 3'h0, 16'hF800);
    rd(psm_pkg::CMD_TEMP_MAX, 3'h0, 16'h7C00);
    riseDone <= 8'h01;
    for (int m = 0; m < 2; m++) begin
      @(posedge core_clk);
      dacMode[0] <= 2'(m);
      wr(psm_pkg::CMD_DAC_CODE, 3'h0, 16'h03FF, 1'b0);
      rd(psm_pkg::CMD_DAC_CODE, 3'h0, 16'h0000);
    end
    dacMode[0] <= psm_pkg::DAC_MODE_HARD;
    wr(psm_pkg::CMD_DAC_CODE, 3'h0, 16'hFFFF, 1'b0);
    rd(psm_pkg::CMD_DAC_CODE, 3'h0, 16'h03FF);
    riseDone <= 8'h00;
    wr(psm_pkg::CMD_DAC_CODE, 3'h0, 16'h0155, 1'b0);
    rd(psm_pkg::CMD_DAC_CODE, 3'h0, 16'h03FF);
    riseDone <= 8'h01;
    dacMode[0] <= psm_pkg::DAC_MODE_SOFT;
    @(posedge core_clk);
    softDone <= 8'h01;
    softCode[0] <= 10'h2AA;
    @(posedge core_clk);
    softDone <= 8'h00;
    softCode[0] <= 10'h155;
    rd(psm_pkg::CMD_DAC_CODE, 3'h0, 16'h02AA);
    wr(psm_pkg::CMD_PG_DELAY, 3'h0, 16'hD3FF, 1'b0);
    rd(psm_pkg::CMD_PG_DELAY, 3'h0, 16'hD3FF);
    wr(psm_pkg::CMD_PG_DELAY, 3'h0, 16'hE807, 1'b0);
    rd(psm_pkg::CMD_PG_DELAY, 3'h0, 16'hE807);
    {shareClkPresent, pgoodOffSourceSel[0], pgoodOnCond[0]} <= 3'h7;
    repeat (4) @(posedge core_clk);
    ticks(3, 1'b1);
    holdPg(1'b0);
    ticks(1, 1'b1);
    waitPg(1'b1);
    pgoodOffPolled[0] <= 1'b1;
    holdPg(1'b1);
    {uvFastComp[0], pgoodOnCond[0]} <= 2'h2;
    waitPg(1'b0);
    {uvFastComp[0], pgoodOffPolled[0], pgoodOffSourceSel[0]} <= 3'h0;
    {shareClkPresent, pgoodOnCond[0]} <= 2'h1;
    repeat (4) @(posedge core_clk);
    ticks(3, 1'b0);
    holdPg(1'b0);
    ticks(1, 1'b0);
    waitPg(1'b1);
    uvFastComp[0] <= 1'b1;
    holdPg(1'b1);
    {pgoodOffPolled[0], pgoodOnCond[0]} <= 2'h2;
    waitPg(1'b0);
    for (int p = 0; p < 2; p++) begin
      pat = p ? 15'h55A5 : 15'h2A5A;
      {alertDriveLow, faultShareDriveLow, addrSelectPinB, addrSelectPinA} <= pat[14:6];
      {chanCtrlPinB, chanCtrlPinA, faultSharePinN} <= pat[5:0];
      rd(psm_pkg::CMD_PAD_STATE, 3'h0, {1'b0, ~pat[14:10], pat[9:0]});
    end
    wr(psm_pkg::CMD_PAD_STATE, 3'h0, 16'hFFFF, 1'b1);
    rd(psm_pkg::CMD_PAD_STATE, 3'h0, {1'b0, ~pat[14:10], pat[9:0]});
    complete_run();
  end
endmodule : test_psm_cmd_regs
